/* core/pwm_core.sv */
// Four-channel pwm with clock tree, pair joining and an AXI4-Lite register slave.
//
// Added by the designer: the AXI4-Lite slave port.
`default_nettype none
`include "pwm_defs.svh"

// Contract
// [RQ1] Four 8-bit, two 16-bit, or mixed outputs.
// [RQ2] Own counter, period, duty; four clock sources.
// [RQ3] Duty selectable from 0 to 100 percent.
// [RQ4] Left-aligned or center-aligned per channel.
// [RQ5] Enabled: new values wait for rollover or disable.
// [RQ6] Disabled: writes reach buffer and latch together.
// [RQ7] Counter write resets counter, latches new values.
// [RQ8] Software can read each channel counter.
// [RQ9] Enabled output overrides pin; otherwise general I/O.
// [RQ10] S0 from A, S1 from B, even 2..512.
// [RQ11] Join bit 7: channel 2 high, pin 2.
// [RQ12] Join bit 6: channel 0 high, pin 0.
// [RQ13] Bits 5..3 divide P by 1..128 for A.
// [RQ14] Bits 2..0 divide P by 1..128 for B.
// [RQ15] Select bits 4,5: clock A or S0.
// [RQ16] Select bits 6,7: clock B or S1.
// [RQ17] Software avoids select changes while channel runs.
// [RQ18] Left mode polarity sets start level.
// [RQ19] Duty counts low time, or high with polarity.
// [RQ20] Enable forces pin output, gates channel clock.
// [RQ21] Scaled clock is A over scale+1, halved.
// [RQ22] Center counts up/down; left resets on match.
// [RQ23] All divided clocks are enable pulses on mclk.
module pwm_core
    import pwm_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire logic [9:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [9:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [3:0]  port_in,
    output logic [3:0]       port_out,
    output logic [3:0]       port_oe
);
    localparam int NCH = 4;

    byte_t      clk_reg;
    byte_t      pol_reg;
    byte_t      scale_reg [2];
    logic [3:0] en_reg;
    logic [3:0] center_reg;
    logic [3:0] gp_data_reg;
    logic [3:0] gp_dir_reg;
    byte_t      cnt_reg [NCH];
    byte_t      per_buf_reg [NCH];
    byte_t      per_act_reg [NCH];
    byte_t      dty_buf_reg [NCH];
    byte_t      dty_act_reg [NCH];
    count_dir_t dir_reg [NCH];
    logic [3:0] wave_reg;
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic [3:0] sync3_reg;
    logic [3:0] pin_reg;
    logic [6:0] pre_reg;
    logic       aw_have_reg;
    logic       w_have_reg;
    logic       w_lane_reg;
    logic [9:0] aw_addr_reg;
    byte_t      w_byte_reg;

    logic       wr_go;
    logic       wr_en;
    logic       en_any;
    byte_t      wr_idx;
    logic       aw_have_next;
    logic       w_have_next;
    logic       bvalid_next;
    logic       rvalid_next;
    logic [1:0] join_w;
    logic [1:0] base_tick;
    logic [1:0] scaled_tick;
    logic [3:0] pin_next;
    wire  [3:0] wr_cnt;
    wire  [3:0] wr_per;
    wire  [3:0] wr_dty;
    wire  [3:0] wide;
    wire  [3:0] idle;
    wire  [3:0] run;
    wire  [3:0] own_en;
    wire  [3:0] latch;
    wire  [3:0] act_pin;
    wire  [3:0] srcsel;
    wire  [3:0] lvl;
    wire  [3:0] wave_next;
    wire wide_t      ec [NCH];
    wire wide_t      ep [NCH];
    wire wide_t      ed [NCH];
    wire step_t      st [NCH];
    wire byte_t      cnt_next [NCH];
    wire byte_t      per_next [NCH];
    wire byte_t      dty_next [NCH];
    wire count_dir_t dir_next [NCH];

    function automatic logic hit(byte_t idx, byte_t base, int off);
        return idx == byte_t'(base + byte_t'(off));
    endfunction

    function automatic logic mapped(byte_t idx);
        return (idx >= `IDX_CLK && idx <= `IDX_SCALE1) || (idx >= `IDX_CNT0 && idx <= `IDX_PIN);
    endfunction

    // A divide-by-2^k enable fires when the low k bits of the prescaler are all ones.
    function automatic logic div_tick(logic [6:0] c, logic [2:0] k);
        logic [6:0] m;
        m = 7'((8'h01 << k) - 8'h01);
        return (c & m) == m;
    endfunction

    function automatic step_t pwm_step(wide_t c, wide_t p, count_dir_t d, logic center);
        step_t s;
        s.cnt    = c + 16'h0001;
        s.dir    = count_up;
        s.reload = 1'b0;
        if (!center) begin
            if (c >= p) begin
                s.cnt    = 16'h0000;
                s.reload = 1'b1;
            end
        end else if (p == 16'h0000) begin
            s.cnt    = 16'h0000;
            s.reload = 1'b1;
        end else if (d == count_down) begin
            if (c == 16'h0000) begin
                s.reload = 1'b1;
            end else begin
                s.cnt = c - 16'h0001;
                s.dir = count_down;
            end
        end else if (c >= p) begin
            s.cnt = c - 16'h0001;
            s.dir = count_down;
        end
        return s;
    endfunction

    // Center mode ignores polarity and is high while the count is below duty.
    function automatic logic pwm_level(wide_t c, wide_t d, logic start_high, logic center);
        return (center || start_high) ? (c < d) : (c >= d);
    endfunction

    function automatic byte_t reg_read(byte_t idx);
        byte_t v;
        v = 8'h00;
        if (idx == `IDX_CLK) v = clk_reg;
        if (idx == `IDX_POL) v = pol_reg;
        if (idx == `IDX_EN) v = {4'h0, en_reg};
        if (idx == `IDX_CENTER) v = {4'h0, center_reg};
        if (idx == `IDX_SCALE0) v = scale_reg[0];
        if (idx == `IDX_SCALE1) v = scale_reg[1];
        if (idx == `IDX_PDATA) v = {4'h0, gp_data_reg};
        if (idx == `IDX_PDIR) v = {4'h0, gp_dir_reg};
        if (idx == `IDX_PIN) v = {4'h0, pin_reg};
        for (int i = 0; i < NCH; i++) begin
            if (hit(idx, `IDX_CNT0, i)) v = cnt_reg[i]; // [RQ8]
            if (hit(idx, `IDX_PER0, i)) v = per_buf_reg[i];
            if (hit(idx, `IDX_DTY0, i)) v = dty_buf_reg[i];
        end
        return v;
    endfunction

    // Bus slave: address and data are taken in either order, the write acts once both are held.
    assign wr_go        = aw_have_reg && w_have_reg && !s_axi_bvalid;
    assign wr_idx       = aw_addr_reg[9:2];
    assign wr_en        = wr_go && w_lane_reg && mapped(wr_idx);
    assign aw_have_next = (aw_have_reg && !wr_go) || (s_axi_awvalid && s_axi_awready);
    assign w_have_next  = (w_have_reg && !wr_go) || (s_axi_wvalid && s_axi_wready);
    assign bvalid_next  = wr_go || (s_axi_bvalid && !s_axi_bready);
    assign rvalid_next  = (s_axi_arvalid && s_axi_arready) || (s_axi_rvalid && !s_axi_rready);

    always_ff @(posedge mclk) begin
        if (srst) begin
            aw_have_reg   <= 1'b0;
            w_have_reg    <= 1'b0;
            w_lane_reg    <= 1'b0;
            aw_addr_reg   <= 10'h000;
            w_byte_reg    <= `RST_BYTE;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `RESP_OKAY;
        end else begin
            aw_have_reg   <= aw_have_next;
            w_have_reg    <= w_have_next;
            s_axi_bvalid  <= bvalid_next;
            s_axi_rvalid  <= rvalid_next;
            s_axi_awready <= !aw_have_next && !bvalid_next;
            s_axi_wready  <= !w_have_next && !bvalid_next;
            s_axi_arready <= !rvalid_next;
            if (s_axi_awvalid && s_axi_awready) aw_addr_reg <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready) begin
                w_byte_reg <= s_axi_wdata[7:0];
                w_lane_reg <= s_axi_wstrb[0];
            end
            if (wr_go) s_axi_bresp <= mapped(wr_idx) ? `RESP_OKAY : `RESP_SLVERR;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rdata <= {24'h000000, reg_read(s_axi_araddr[9:2])};
                s_axi_rresp <= mapped(s_axi_araddr[9:2]) ? `RESP_OKAY : `RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            clk_reg      <= `RST_BYTE;
            pol_reg      <= `RST_BYTE;
            scale_reg[0] <= `RST_BYTE;
            scale_reg[1] <= `RST_BYTE;
            en_reg       <= 4'h0;
            center_reg   <= 4'h0;
            gp_data_reg  <= 4'h0;
            gp_dir_reg   <= 4'h0;
        end else if (wr_en) begin
            if (wr_idx == `IDX_CLK) clk_reg <= w_byte_reg;
            if (wr_idx == `IDX_POL) pol_reg <= w_byte_reg;
            if (wr_idx == `IDX_EN) en_reg <= w_byte_reg[3:0];
            if (wr_idx == `IDX_CENTER) center_reg <= w_byte_reg[3:0];
            if (wr_idx == `IDX_SCALE0) scale_reg[0] <= w_byte_reg;
            if (wr_idx == `IDX_SCALE1) scale_reg[1] <= w_byte_reg;
            if (wr_idx == `IDX_PDATA) gp_data_reg <= w_byte_reg[3:0];
            if (wr_idx == `IDX_PDIR) gp_dir_reg <= w_byte_reg[3:0];
        end
    end

    // Clock tree: one free-running prescaler, held at zero while every channel is off.
    assign en_any       = |en_reg;
    assign join_w       = {clk_reg[`BIT_JOIN23], clk_reg[`BIT_JOIN01]}; // [RQ11] [RQ12]
    assign base_tick[0] = div_tick(pre_reg, clk_reg[`CKA_HI:`CKA_LO]); // [RQ13] [RQ23]
    assign base_tick[1] = div_tick(pre_reg, clk_reg[`CKB_HI:`CKB_LO]); // [RQ14] [RQ23]

    for (genvar p = 0; p < 2; p++) begin : g_pair
        pwm_scaler u_scaler (
            .mclk     (mclk),
            .srst     (srst),
            .tick_in  (base_tick[p]),
            .scale    (scale_reg[p]),
            .load     (wr_en && hit(wr_idx, `IDX_SCALE0, p)),
            .tick_out (scaled_tick[p])
        );
    end

    // A joined pair runs one 16-bit engine in its even channel; the odd one only holds the low byte.
    for (genvar i = 0; i < NCH; i++) begin : g_ch
        localparam int P = i / 2;
        localparam int L = (i % 2 == 0) ? i + 1 : i;
        localparam int O = (i % 2 == 1) ? i - 1 : i;
        assign wr_cnt[i]  = wr_en && hit(wr_idx, `IDX_CNT0, i);
        assign wr_per[i]  = wr_en && hit(wr_idx, `IDX_PER0, i);
        assign wr_dty[i]  = wr_en && hit(wr_idx, `IDX_DTY0, i);
        assign wide[i]    = join_w[P] && (i % 2 == 0); // [RQ1]
        assign idle[i]    = join_w[P] && (i % 2 == 1); // [RQ11] [RQ12]
        assign own_en[i]  = idle[i] ? en_reg[O] : en_reg[i];
        assign srcsel[i]  = wide[i] ? pol_reg[`SEL_LO + L] : pol_reg[`SEL_LO + i]; // [RQ15] [RQ16]
        assign run[i]     = en_reg[i] && !idle[i]
                            && (srcsel[i] ? scaled_tick[P] : base_tick[P]); // [RQ2] [RQ20]
        assign ec[i]      = wide[i] ? {cnt_reg[i], cnt_reg[L]} : {8'h00, cnt_reg[i]};
        assign ep[i]      = wide[i] ? {per_act_reg[i], per_act_reg[L]} : {8'h00, per_act_reg[i]};
        assign ed[i]      = wide[i] ? {dty_act_reg[i], dty_act_reg[L]} : {8'h00, dty_act_reg[i]};
        assign st[i]      = pwm_step(ec[i], ep[i], dir_reg[i], center_reg[i]); // [RQ4] [RQ22]
        assign lvl[i]     = pwm_level(st[i].cnt, ed[i], pol_reg[i], center_reg[i]); // [RQ18] [RQ19]
        assign latch[i]   = wr_cnt[i] || !own_en[i]
                            || (idle[i] ? run[O] && st[O].reload : run[i] && st[i].reload); // [RQ5]
        assign cnt_next[i] = wr_cnt[i] ? 8'h00 : // [RQ7]
                             idle[i] ? (run[O] ? st[O].cnt[7:0] : cnt_reg[i]) :
                             !run[i] ? cnt_reg[i] :
                             wide[i] ? st[i].cnt[15:8] : st[i].cnt[7:0];
        assign per_next[i] = (wr_per[i] && !own_en[i]) ? w_byte_reg : // [RQ6]
                             latch[i] ? per_buf_reg[i] : per_act_reg[i];
        assign dty_next[i] = (wr_dty[i] && !own_en[i]) ? w_byte_reg : // [RQ6]
                             latch[i] ? dty_buf_reg[i] : dty_act_reg[i];
        assign dir_next[i] = wr_cnt[i] ? count_up : run[i] ? st[i].dir : dir_reg[i];
        assign wave_next[i] = run[i] ? lvl[i] : wave_reg[i]; // [RQ3]
        assign act_pin[i] = en_reg[i] && !idle[i]; // [RQ9] [RQ20]
    end

    always_ff @(posedge mclk) begin
        for (int i = 0; i < NCH; i++) begin
            if (srst) begin
                cnt_reg[i]     <= `RST_BYTE;
                per_buf_reg[i] <= `RST_PER;
                per_act_reg[i] <= `RST_PER;
                dty_buf_reg[i] <= `RST_BYTE;
                dty_act_reg[i] <= `RST_BYTE;
                dir_reg[i]     <= count_up;
            end else begin
                cnt_reg[i]     <= cnt_next[i];
                per_act_reg[i] <= per_next[i];
                dty_act_reg[i] <= dty_next[i];
                dir_reg[i]     <= dir_next[i];
                if (wr_per[i]) per_buf_reg[i] <= w_byte_reg;
                if (wr_dty[i]) dty_buf_reg[i] <= w_byte_reg;
            end
        end
    end

    // A pin input bit is accepted once the second and third stages agree.
    assign pin_next = (sync2_reg & ~(sync2_reg ^ sync3_reg)) | (pin_reg & (sync2_reg ^ sync3_reg));

    always_ff @(posedge mclk) begin
        if (srst) begin
            pre_reg   <= 7'h00;
            wave_reg  <= 4'h0;
            sync1_reg <= 4'h0;
            sync2_reg <= 4'h0;
            sync3_reg <= 4'h0;
            pin_reg   <= 4'h0;
            port_out  <= 4'h0;
            port_oe   <= 4'h0;
        end else begin
            pre_reg   <= en_any ? pre_reg + 7'h01 : 7'h00;
            wave_reg  <= wave_next;
            sync1_reg <= port_in;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            pin_reg   <= pin_next;
            port_out  <= (act_pin & wave_reg) | (~act_pin & gp_data_reg); // [RQ9]
            port_oe   <= act_pin | gp_dir_reg; // [RQ20]
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);

    property p_left_match;
        run[0] && !center_reg[0] && !wide[0] && !wr_cnt[0] && ec[0] >= ep[0]
            |=> cnt_reg[0] == 8'h00;
    endproperty
    a_left_match: assert property (p_left_match) // [RQ22]
        else $error("Left-aligned counter did not restart on period match.");

    property p_left_start;
        run[0] && !center_reg[0] && !wide[0] && !wr_cnt[0] && ec[0] >= ep[0] && ed[0] != 16'h0000
            |=> wave_reg[0] == $past(pol_reg[0]);
    endproperty
    a_left_start: assert property (p_left_start) // [RQ18]
        else $error("Period start level does not follow polarity.");

    property p_cnt_write;
        wr_cnt[0] |=> cnt_reg[0] == 8'h00 && per_act_reg[0] == $past(per_buf_reg[0]);
    endproperty
    a_cnt_write: assert property (p_cnt_write) // [RQ7]
        else $error("Counter write did not reset and latch.");

    property p_buffer_hold;
        own_en[2] && wr_per[2] && !latch[2] |=> per_act_reg[2] == $past(per_act_reg[2]);
    endproperty
    a_buffer_hold: assert property (p_buffer_hold) // [RQ5]
        else $error("Active period changed before rollover.");

    property p_direct;
        wr_dty[0] && !own_en[0] |=> dty_act_reg[0] == $past(w_byte_reg);
    endproperty
    a_direct: assert property (p_direct) // [RQ6]
        else $error("Disabled duty write did not reach the latch.");

    property p_pin_drive;
        en_reg[0] |=> port_oe[0];
    endproperty
    a_pin_drive: assert property (p_pin_drive) // [RQ9]
        else $error("Enabled channel does not drive its pin.");

    property p_pin_free;
        clk_reg[`BIT_JOIN23] |=> port_oe[3] == $past(gp_dir_reg[3]);
    endproperty
    a_pin_free: assert property (p_pin_free) // [RQ11]
        else $error("Joined low channel pin is not general I/O.");

    property p_div_a;
        en_any && base_tick[0] && clk_reg[`CKA_HI:`CKA_LO] == 3'h2
            |=> !base_tick[0] || clk_reg[`CKA_HI:`CKA_LO] != 3'h2;
    endproperty
    a_div_a: assert property (p_div_a) // [RQ13]
        else $error("Clock A fired on consecutive cycles at divide by four.");

    property p_center_turn;
        run[0] && center_reg[0] && !wide[0] && !wr_cnt[0] && dir_reg[0] == count_up
            && ep[0] != 16'h0000 && ec[0] >= ep[0] |=> dir_reg[0] == count_down;
    endproperty
    a_center_turn: assert property (p_center_turn) // [RQ22]
        else $error("Center counter did not reverse at period.");

    property p_zero_duty;
        run[0] && !center_reg[0] && pol_reg[0] && ed[0] == 16'h0000 |=> !wave_reg[0];
    endproperty
    a_zero_duty: assert property (p_zero_duty) // [RQ3]
        else $error("Zero duty with high start produced a high level.");

    property p_bus_resp;
        wr_go |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready;
    endproperty
    a_bus_resp: assert property (p_bus_resp)
        else $error("Write response missing after write.");

    c_wide_run: cover property (run[0] && wide[0]);
    c_center_turn: cover property (run[0] && center_reg[0] && dir_reg[0] == count_down);
    c_cnt_write: cover property (wr_cnt[2] && !en_reg[2]);
    c_scaled: cover property (scaled_tick[1] && run[2]);
endmodule

`default_nettype wire

/* core/pwm_defs.svh */
// Register indices, field positions, reset values and bus codes of the pwm block.
`ifndef PWM_DEFS_SVH
`define PWM_DEFS_SVH

`define IDX_CLK      8'h40
`define IDX_POL      8'h41
`define IDX_EN       8'h42
`define IDX_CENTER   8'h43
`define IDX_SCALE0   8'h44
`define IDX_SCALE1   8'h45
`define IDX_CNT0     8'h48
`define IDX_PER0     8'h4C
`define IDX_DTY0     8'h50
`define IDX_PDATA    8'h54
`define IDX_PDIR     8'h55
`define IDX_PIN      8'h56

`define BIT_JOIN23   7
`define BIT_JOIN01   6
`define CKA_HI       5
`define CKA_LO       3
`define CKB_HI       2
`define CKB_LO       0
`define SEL_LO       4

`define RST_BYTE     8'h00
`define RST_PER      8'hFF
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2

`endif

/* core/pwm_pkg.sv */
// Types shared by the pwm core and its scaler.
`default_nettype none

package pwm_pkg;
    typedef logic [7:0]  byte_t;
    typedef logic [15:0] wide_t;
    typedef enum logic {count_up, count_down} count_dir_t;
    typedef struct packed {
        wide_t      cnt;
        count_dir_t dir;
        logic       reload;
    } step_t;
endpackage

`default_nettype wire

/* core/pwm_scaler.sv */
// Scaled clock enable: divides an input enable by (scale + 1) and then by two.
`default_nettype none
`include "pwm_defs.svh"

module pwm_scaler
    import pwm_pkg::*;
(
    input  wire logic  mclk,
    input  wire logic  srst,
    input  wire logic  tick_in,
    input  wire byte_t scale,
    input  wire logic  load,
    output logic       tick_out
);
    byte_t count_reg;
    logic  half_reg;
    logic  wrap;

    assign wrap = tick_in && (count_reg == 8'h00);

    always_ff @(posedge mclk) begin
        if (srst) begin
            count_reg <= `RST_BYTE;
            half_reg  <= 1'b0;
            tick_out  <= 1'b0;
        end else if (load) begin
            count_reg <= scale;
            half_reg  <= 1'b0;
            tick_out  <= 1'b0;
        end else begin
            tick_out <= wrap && half_reg; // [RQ10] [RQ21]
            if (wrap) begin
                count_reg <= scale;
                half_reg  <= ~half_reg;
            end else if (tick_in) begin
                count_reg <= count_reg - 8'h01;
            end
        end
    end
endmodule

`default_nettype wire

/* dv/pin_load.sv */
// Model of the outside loads on the four shared pins.
`default_nettype none
module pin_load (
    input  wire logic [3:0] port_out,
    input  wire logic [3:0] port_oe,
    input  wire logic [3:0] ext,
    output logic [3:0]      port_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // A pin reads the block's own drive while enabled, else the outside level.
    assign port_in = (port_oe & port_out) | (~port_oe & ext);
endmodule
`default_nettype wire

/* dv/tb.sv */
// Self-checking bench for the four-channel pwm block.
`default_nettype none
module tb;
    import pwm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk, srst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [9:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, r, v;
    logic [3:0]  wstrb, port_out, port_oe, port_in, ext;
    logic [1:0]  bresp, rresp;
    logic [7:0]  k, s;
    int          fail_count, checks_done, cycles = 0;
    int          seed;
    pwm_core dut_u (.mclk(mclk), .srst(srst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .port_in(port_in), .port_out(port_out), .port_oe(port_oe));
    pin_load load_u (.port_out(port_out), .port_oe(port_oe), .ext(ext), .port_in(port_in));
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            end_sim();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er = 2'h0);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        @(posedge mclk);
        awaddr <= {idx, 2'b00};
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge mclk);
            aw = aw | (awready === 1'b1);
            w = w | (wready === 1'b1);
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1) @(posedge mclk);
        bready <= 1'b0;
        chk(32'(bresp), 32'(er));
    endtask
    task automatic rd(input logic [7:0] idx, output logic [31:0] q, input logic [1:0] er = 2'h0);
        @(posedge mclk);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge mclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge mclk); while (rvalid !== 1'b1);
        q = rdata;
        rready <= 1'b0;
        chk(32'(rresp), 32'(er));
    endtask
    function automatic int lh(int per, int dty, logic pol);
        int m;
        m = (dty < per + 1) ? dty : per + 1;
        return pol ? m : per + 1 - m;
    endfunction
    // Programs one channel or joined pair while stopped, then counts high cycles on its pin.
    task automatic run(input logic [7:0] c, ck, pl, cn, sc, input logic [15:0] per, dty,
                       input int prd, input int dv, input int hi);
        int h;
        logic j;
        h = 0;
        j = c[1] ? ck[7] : ck[6];
        wr(8'h42, 8'h00);
        wr(8'h40, ck);
        wr(8'h41, pl);
        wr(8'h43, cn);
        wr(8'h44 + {7'h00, c[1]}, sc);
        wr(8'h4C + c, j ? per[15:8] : per[7:0]);
        wr(8'h4D + c, per[7:0]);
        wr(8'h50 + c, j ? dty[15:8] : dty[7:0]);
        wr(8'h51 + c, dty[7:0]);
        wr(8'h48 + c, 8'h5A);
        wr(8'h42, 8'(j ? 3 : 1) << c);
        repeat (3 * prd * dv) @(posedge mclk);
        repeat (4 * prd * dv) begin
            @(posedge mclk);
            if (port_out[c] === 1'b1) h++;
        end
        chk(h, 4 * dv * hi);
        chk(32'(port_oe[c]), 1);
        if (j) chk(32'(port_oe[c + 1]), 0);
        rd(8'h48 + c + {7'h00, j}, r);
        chk(32'(r <= {24'h000000, per[7:0]}), 1);
        $display("test ch %0d clk %h sel %h done", c, ck, pl);
    endtask
    initial begin
        seed = 32'h350A;
        srst = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 10'h000;
        araddr = 10'h000;
        wdata = 32'h00000000;
        wstrb = 4'hF;
        ext = 4'h0;
        repeat (3) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        rd(8'h40, r);
        chk(r, 32'h00000000);
        rd(8'h41, r);
        chk(r, 32'h00000000);
        rd(8'h4C, r);
        chk(r, 32'h000000FF);
        rd(8'h7F, r, 2'h2);
        chk(r, 32'h00000000);
        wr(8'h7F, 8'h55, 2'h2);
        wstrb <= 4'h0;
        wr(8'h40, 8'hFF);
        wstrb <= 4'hF;
        rd(8'h40, r);
        chk(r, 32'h00000000);
        for (int i = 0; i < 4; i++) begin
            v = $random(seed);
            wr(8'h40 + 8'(i[0]), v[7:0]);
            rd(8'h40 + 8'(i[0]), r);
            chk(r, {24'h000000, v[7:0]});
        end
        v = $random(seed);
        wr(8'h42, 8'h00);
        wr(8'h55, 8'h0F);
        wr(8'h54, v[7:0]);
        repeat (2) @(posedge mclk);
        chk(32'(port_oe), 32'h0000000F);
        chk(32'(port_out), 32'(v[3:0]));
        wr(8'h55, 8'h00);
        ext <= v[7:4];
        repeat (6) @(posedge mclk);
        rd(8'h56, r);
        chk(r, 32'(v[7:4]));
        $display("test registers and pins done");
        for (int i = 0; i < 8; i++) begin
            v = $random(seed);
            k = (v[1:0] == 2'b11) ? 8'h02 : {6'h00, v[1:0]};
            s = {6'h00, v[3:2]};
            run(8'h00, k << 3, {7'h00, i[2]}, 8'h00, 8'h00, 16'h0003, 16'(i % 4 + i[1]),
                4, 1 << k, lh(3, i % 4 + i[1], i[2]));
        end
        run(8'h02, k, 8'h04, 8'h00, 8'h00, 16'h0003, 16'h0001, 4, 1 << k, 1);
        wr(8'h4E, 8'h07);
        rd(8'h4E, r);
        chk(r, 32'h00000007);
        run(8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 16'h0003, 16'h0002, 6, 1, 3);
        run(8'h00, 8'h00, 8'h10, 8'h00, s, 16'h0003, 16'h0001, 4, 2 * (s + 1), 3);
        run(8'h02, 8'h00, 8'h40, 8'h00, s, 16'h0003, 16'h0001, 4, 2 * (s + 1), 3);
        run(8'h00, 8'h40, 8'h20, 8'h00, 8'h00, 16'h0003, 16'h0001, 4, 2, 3);
        run(8'h02, 8'h80, 8'h80, 8'h00, 8'h00, 16'h0003, 16'h0001, 4, 2, 3);
        end_sim();
    end
endmodule
`default_nettype wire
